// file: swc_key_if.sv
// Strobe, key setup and key events between control and sampler.
// Both sides sit on pclk.
`timescale 1ns/100ps
interface swc_key_if;
   logic       tick;
   logic       direct_enable;
   logic       key_role_swap;
   logic [2:0] key_mask_select;
   logic       run_event;
   logic       lap_event;
   modport ctrl (output tick, direct_enable, key_role_swap, key_mask_select,
                 input  run_event, lap_event);
   modport keys (input  tick, direct_enable, key_role_swap, key_mask_select,
                 output run_event, lap_event);
endinterface : swc_key_if

// file: swc_key_model.sv
// Key partner: direct key pins and mask keys.
// Assumes keys are high while pressed.
`timescale 1ns/100ps
module swc_key_model (
   input  wire logic pclk,      // Clock
   output logic      key_a,     // First direct pin
   output logic      key_b,     // Second direct pin
   output logic [5:0] mask_keys // Mask key pins
);
   initial {key_a, key_b, mask_keys} = 8'h00;
   // Press spans several strobes so the sampler sees it
   task automatic press(input logic pin);
      @(posedge pclk);
      {key_b, key_a} <= pin ? 2'b10 : 2'b01;
      repeat (32) @(posedge pclk);
      {key_b, key_a} <= 2'b00;
      repeat (32) @(posedge pclk);
   endtask : press
   task automatic hold_mask(input logic [5:0] m);
      @(posedge pclk);
      mask_keys <= m;
      repeat (16) @(posedge pclk);
   endtask : hold_mask
endmodule : swc_key_model

// file: swc_keys.sv
// Direct key sampler: sync, strobe sampling, role swap, mask, events.
// Assumes pins are high while pressed and debounced outside.
`timescale 1ns/100ps
module swc_keys (
   input  wire logic                         pclk,        // APB clock
   input  wire logic                         presetn,     // Async reset
   input  wire logic                         key_pin_a,   // First key pin
   input  wire logic                         key_pin_b,   // Second key pin
   input  wire logic [swc_pkg::MASK_KEYS-1:0] mask_keys,  // Mask key pins
   swc_key_if.keys                           kif          // To control
);
   localparam int NPIN = swc_pkg::MASK_KEYS + 2;

   logic [NPIN-1:0] sync1;
   logic [NPIN-1:0] sync2;
   logic            run_prev;
   logic            lap_prev;
   logic            mask_prev;
   logic            blocked;
   logic            run_now;
   logic            lap_now;
   logic            mask_now;
   logic            rise_any;

   function automatic logic [swc_pkg::MASK_KEYS-1:0] mask_decode(
      input logic [2:0] sel);
      case (sel)
         3'h1:    mask_decode = 6'h01;
         3'h2:    mask_decode = 6'h03;
         3'h3:    mask_decode = 6'h07;
         3'h4:    mask_decode = 6'h04;
         3'h5:    mask_decode = 6'h0c;
         3'h6:    mask_decode = 6'h1c;
         3'h7:    mask_decode = 6'h3c;
         default: mask_decode = 6'h00;
      endcase
   endfunction : mask_decode

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {mask_keys, key_pin_b, key_pin_a};
         sync2 <= sync1;
      end
   end

   // R10 pin role select
   assign run_now  = kif.key_role_swap ? sync2[1] : sync2[0];
   assign lap_now  = kif.key_role_swap ? sync2[0] : sync2[1];
   // R11 mask combination
   assign mask_now = |(sync2[NPIN-1:2] & mask_decode(kif.key_mask_select));
   assign rise_any = (run_now & ~run_prev) | (lap_now & ~lap_prev);

   // R04 sample on strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_prev  <= 1'b0;
         lap_prev  <= 1'b0;
         mask_prev <= 1'b0;
      end else if (kif.tick) begin
         run_prev  <= run_now;
         lap_prev  <= lap_now;
         mask_prev <= mask_now;
      end
   end

   // R12 hold off while mask concurrent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blocked <= 1'b0;
      end else if (kif.tick) begin
         if (rise_any && mask_prev) begin
            blocked <= 1'b1;
         end else if (!run_now && !lap_now) begin
            blocked <= 1'b0;
         end
      end
   end

   // R04 rising edge events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kif.run_event <= 1'b0;
         kif.lap_event <= 1'b0;
      end else begin
         kif.run_event <= kif.tick & kif.direct_enable & ~blocked &
                          ~mask_prev & run_now & ~run_prev;
         kif.lap_event <= kif.tick & kif.direct_enable & ~blocked &
                          ~mask_prev & lap_now & ~lap_prev;
      end
   end
endmodule : swc_keys

// file: swc_pkg.sv
// Constants of the stopwatch control and its key sampler.
// Assumes a 125 MHz APB clock and a 1,024 Hz sampling/count rate.
package swc_pkg;
   localparam int          ADDR_W      = 18;
   localparam int          CLK_HZ      = 125_000_000;
   localparam int          SAMPLE_HZ   = 1024;
   localparam int          TICK_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int          MASK_KEYS   = 6;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CLK_EN  = 16'hff16;
   localparam logic [15:0] IDX_DIR_CFG = 16'hff48;
   localparam logic [15:0] IDX_KEY_MSK = 16'hff49;
   localparam logic [15:0] IDX_CTL     = 16'hff4a;
   localparam logic [15:0] IDX_CAP_THO = 16'hff4b;
   localparam logic [15:0] IDX_CAP_HUN = 16'hff4c;
   localparam logic [15:0] IDX_CAP_TEN = 16'hff4d;
   localparam logic [15:0] IDX_INT_EN  = 16'hffed;
   localparam logic [15:0] IDX_INT_FLG = 16'hfffd;
   // Field positions
   localparam int          CKE_SWC     = 1;
   localparam int          DIR_EN      = 0;
   localparam int          DIR_SWAP    = 1;
   localparam int          CTL_CLEAR   = 0;
   localparam int          CTL_RUN     = 1;
   localparam int          CTL_RENEW   = 2;
   localparam int          CTL_LCARRY  = 3;
   localparam int          IRQ_TENTHS  = 0;
   localparam int          IRQ_UNIT    = 1;
   localparam int          IRQ_LAP     = 2;
   localparam int          IRQ_RUN     = 3;
   // Reset values and BCD limits
   localparam logic [3:0]  NIB_RST     = 4'h0;
   localparam logic [2:0]  MSK_RST     = 3'h0;
   localparam logic [3:0]  BCD_NINE    = 4'h9;
endpackage : swc_pkg

// file: swc_stopwatch.sv
// Stopwatch control, capture and interrupt logic behind an APB slave.
// Assumes a free-running pclk; keys and mask keys arrive asynchronously.
//
// Summary of operation
// R01: 10 Hz event on hundredths overflow, 1 Hz on tenths overflow.
// R02: Overflow is digit 9 to 0; sets matching rate flag.
// R03: Rate flags set regardless of mask; each gated by own enable.
// R04: Keys sampled on 1,024 Hz strobe; events on rising sampled level.
// R05: Key run and lap flags set even when masked.
// R06: Software clears port interrupt selects for the two key pins.
// R07: Clock enable bit one runs stopwatch, zero stops; reset zero.
// R08: Direct enable gives keys run/stop and lap control; reset zero.
// R09: Direct enable change applies at next 1,024 Hz strobe.
// R10: Role swap bit exchanges run/stop and lap pins; reset zero.
// R11: Three-bit mask select picks mask key group; reset zero.
// R12: Mask key concurrent with run or lap ignores them until released.
// R13: Clear bit zeros counter; running continues, stopped stays zero.
// R14: Clear leaves captured digits untouched.
// R15: Clear bit is write-only, reads zero, zero write ignored.
// R16: Run bit one starts, zero stops; count kept while stopped.
// R17: Software run writes ignored while direct input enabled.
// R18: Run bit reads true running state; resets zero.
// R19: Four interrupt enables readable, writable, reset zero.
// R20: Four flags read events; one clears, zero no effect.
// R21: Carry request and renewal flags are read-only upper bits.
// R22: On hold entry carry request copies unit rate flag.
// R23: Tenths read after renewal sets renewal flag, keeps hold.
// R24: Thousandths read enters hold latching the counter.
// R25: Hold stays until tenths read; released unless renewed.
// R26: Each request high while flag and enable both one.
// R27: Capture digits read-only, reset zero, ignore writes.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module swc_stopwatch #(
   parameter int TICK_CYCLES = swc_pkg::TICK_CYCLES
) (
   input  wire logic                          pclk,           // APB clock
   input  wire logic                          presetn,        // Async reset
   input  wire logic                          psel,           // Select
   input  wire logic                          penable,        // Access phase
   input  wire logic                          pwrite,         // Write
   input  wire logic [swc_pkg::ADDR_W-1:0]    paddr,          // Byte addr
   input  wire logic [31:0]                   pwdata,         // Write data
   output logic      [31:0]                   prdata,         // Read data
   output logic                               pready,         // Ready
   output logic                               pslverr,        // Error
   input  wire logic                          direct_key_pin_a, // Key A
   input  wire logic                          direct_key_pin_b, // Key B
   input  wire logic [swc_pkg::MASK_KEYS-1:0] mask_key_in,    // Mask keys
   output logic                               irq_key_run,    // Run irq
   output logic                               irq_key_lap,    // Lap irq
   output logic                               irq_unit_rate,  // 1 Hz irq
   output logic                               irq_tenths_rate // 10 Hz irq
);
   localparam int TW = $clog2(TICK_CYCLES);

   swc_key_if kif ();

   logic [TW-1:0] tick_cnt;
   logic          tick;
   logic [3:0]    clk_en;
   logic          direct_input_enable;
   logic          dir_eff;
   logic          key_role_swap;
   logic [2:0]    key_mask_select;
   logic [3:0]    int_enable;
   logic [3:0]    int_flag;
   logic          running;
   logic          run_pend;
   logic          run_pend_val;
   logic [3:0]    cnt_tho;
   logic [3:0]    cnt_hun;
   logic [3:0]    cnt_ten;
   logic [3:0]    thousandths_digit;
   logic [3:0]    hundredths_digit;
   logic [3:0]    tenths_digit;
   logic          holding;
   logic          renew_pend;
   logic          capture_renewed_flag;
   logic          lap_carry_request_flag;
   logic          access;
   logic          wr;
   logic          rd;
   logic          mapped;
   logic          count_en;
   logic          ovf_hun;
   logic          ovf_ten;
   logic          cap_load;
   logic          rd_tho;
   logic          rd_ten;
   logic [3:0]    flag_set;
   logic [3:0]    flag_clr;
   logic [3:0]    rd_mux;

   function automatic logic hit(input logic [swc_pkg::ADDR_W-1:0] a,
                                input logic [15:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   function automatic logic [3:0] bcd_inc(input logic [3:0] d);
      bcd_inc = (d == swc_pkg::BCD_NINE) ? 4'h0 : d + 4'h1;
   endfunction : bcd_inc

   swc_keys u_keys (
      .pclk      (pclk),
      .presetn   (presetn),
      .key_pin_a (direct_key_pin_a),
      .key_pin_b (direct_key_pin_b),
      .mask_keys (mask_key_in),
      .kif       (kif)
   );

   assign kif.tick            = tick;
   assign kif.direct_enable   = dir_eff;
   assign kif.key_role_swap   = key_role_swap;
   assign kif.key_mask_select = key_mask_select;

   // Bus decode; the slave never waits
   assign access  = psel & penable;
   assign wr      = access & pwrite;
   assign rd      = access & ~pwrite;
   assign mapped  = hit(paddr, swc_pkg::IDX_CLK_EN)
                  | hit(paddr, swc_pkg::IDX_DIR_CFG)
                  | hit(paddr, swc_pkg::IDX_KEY_MSK)
                  | hit(paddr, swc_pkg::IDX_CTL)
                  | hit(paddr, swc_pkg::IDX_CAP_THO)
                  | hit(paddr, swc_pkg::IDX_CAP_HUN)
                  | hit(paddr, swc_pkg::IDX_CAP_TEN)
                  | hit(paddr, swc_pkg::IDX_INT_EN)
                  | hit(paddr, swc_pkg::IDX_INT_FLG);
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;
   assign rd_tho  = rd & hit(paddr, swc_pkg::IDX_CAP_THO);
   assign rd_ten  = rd & hit(paddr, swc_pkg::IDX_CAP_TEN);

   // 1,024 Hz strobe, one pclk wide, stands for the falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick     <= (tick_cnt == TW'(TICK_CYCLES - 1));
         tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ?
                     '0 : tick_cnt + TW'(1);
      end
   end

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_en              <= swc_pkg::NIB_RST;
         direct_input_enable <= 1'b0;
         key_role_swap       <= 1'b0;
         key_mask_select     <= swc_pkg::MSK_RST;
         int_enable          <= swc_pkg::NIB_RST;
      end else if (wr) begin
         // R07 clock enable store
         if (hit(paddr, swc_pkg::IDX_CLK_EN))
            clk_en <= pwdata[3:0];
         // R08 direct enable store
         if (hit(paddr, swc_pkg::IDX_DIR_CFG)) begin
            direct_input_enable <= pwdata[swc_pkg::DIR_EN];
            // R10 role swap store
            key_role_swap       <= pwdata[swc_pkg::DIR_SWAP];
         end
         // R11 mask select store
         if (hit(paddr, swc_pkg::IDX_KEY_MSK))
            key_mask_select <= pwdata[2:0];
         // R19 enable store
         if (hit(paddr, swc_pkg::IDX_INT_EN))
            int_enable <= pwdata[3:0];
      end
   end

   // R09 apply direct enable on strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_eff <= 1'b0;
      end else if (tick) begin
         dir_eff <= direct_input_enable;
      end
   end

   // Run state: software request waits for the strobe, keys toggle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running      <= 1'b0;
         run_pend     <= 1'b0;
         run_pend_val <= 1'b0;
      end else begin
         // R17 software run only when direct off
         if (wr && hit(paddr, swc_pkg::IDX_CTL) && !dir_eff) begin
            // R16 run or stop request
            run_pend     <= 1'b1;
            run_pend_val <= pwdata[swc_pkg::CTL_RUN];
         end else if (tick) begin
            run_pend     <= 1'b0;
         end
         if (kif.run_event) begin
            running <= ~running;
         end else if (tick && run_pend && !dir_eff) begin
            running <= run_pend_val;
         end
      end
   end

   // R07 counting needs clock enable
   assign count_en = tick & running & clk_en[swc_pkg::CKE_SWC];
   // R02 overflow is nine to zero
   assign ovf_hun  = count_en & (cnt_tho == swc_pkg::BCD_NINE)
                              & (cnt_hun == swc_pkg::BCD_NINE);
   assign ovf_ten  = ovf_hun & (cnt_ten == swc_pkg::BCD_NINE);

   // BCD counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_tho <= swc_pkg::NIB_RST;
         cnt_hun <= swc_pkg::NIB_RST;
         cnt_ten <= swc_pkg::NIB_RST;
      end else if (wr && hit(paddr, swc_pkg::IDX_CTL)
                   && pwdata[swc_pkg::CTL_CLEAR]) begin
         // R13 clear counter only
         cnt_tho <= swc_pkg::NIB_RST;
         cnt_hun <= swc_pkg::NIB_RST;
         cnt_ten <= swc_pkg::NIB_RST;
      end else if (count_en) begin
         cnt_tho <= bcd_inc(cnt_tho);
         if (cnt_tho == swc_pkg::BCD_NINE)
            cnt_hun <= bcd_inc(cnt_hun);
         if (ovf_hun)
            cnt_ten <= bcd_inc(cnt_ten);
      end
   end

   // R24 thousandths read or lap loads buffer
   assign cap_load = kif.lap_event | (rd_tho & ~holding);

   // R14 capture untouched by clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thousandths_digit <= swc_pkg::NIB_RST;
         hundredths_digit  <= swc_pkg::NIB_RST;
         tenths_digit      <= swc_pkg::NIB_RST;
      end else if (cap_load) begin
         thousandths_digit <= cnt_tho;
         hundredths_digit  <= cnt_hun;
         tenths_digit      <= cnt_ten;
      end
   end

   // Hold, renewal and carry request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         holding                <= 1'b0;
         renew_pend             <= 1'b0;
         capture_renewed_flag   <= 1'b0;
         lap_carry_request_flag <= 1'b0;
      end else begin
         // R25 hold until tenths read
         if (cap_load)
            holding <= 1'b1;
         else if (rd_ten && !renew_pend)
            holding <= 1'b0;
         if (kif.lap_event && holding)
            renew_pend <= 1'b1;
         else if (rd_ten)
            renew_pend <= 1'b0;
         // R23 renewal flag on tenths read
         if (rd_ten)
            capture_renewed_flag <= renew_pend;
         // R22 carry request at hold entry
         if (cap_load)
            lap_carry_request_flag <= int_flag[swc_pkg::IRQ_UNIT];
      end
   end

   // R01 rate events R03 unmasked R05 key events
   always_comb begin
      flag_set                      = 4'h0;
      flag_set[swc_pkg::IRQ_TENTHS] = ovf_hun;
      flag_set[swc_pkg::IRQ_UNIT]   = ovf_ten;
      flag_set[swc_pkg::IRQ_LAP]    = kif.lap_event;
      flag_set[swc_pkg::IRQ_RUN]    = kif.run_event;
   end
   assign flag_clr = (wr && hit(paddr, swc_pkg::IDX_INT_FLG)) ?
                     pwdata[3:0] : 4'h0;

   // R20 one clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_flag <= swc_pkg::NIB_RST;
      end else begin
         int_flag <= (int_flag & ~flag_clr) | flag_set;
      end
   end

   // R26 request is flag and enable
   assign irq_tenths_rate = int_flag[swc_pkg::IRQ_TENTHS]
                          & int_enable[swc_pkg::IRQ_TENTHS];
   assign irq_unit_rate   = int_flag[swc_pkg::IRQ_UNIT]
                          & int_enable[swc_pkg::IRQ_UNIT];
   assign irq_key_lap     = int_flag[swc_pkg::IRQ_LAP]
                          & int_enable[swc_pkg::IRQ_LAP];
   assign irq_key_run     = int_flag[swc_pkg::IRQ_RUN]
                          & int_enable[swc_pkg::IRQ_RUN];

   // Read mux
   always_comb begin
      rd_mux = 4'h0;
      if (hit(paddr, swc_pkg::IDX_CLK_EN))
         rd_mux = clk_en;
      if (hit(paddr, swc_pkg::IDX_DIR_CFG))
         rd_mux = {2'b00, key_role_swap, direct_input_enable};
      if (hit(paddr, swc_pkg::IDX_KEY_MSK))
         rd_mux = {1'b0, key_mask_select};
      // R15 clear reads zero R18 true state R21 status bits
      if (hit(paddr, swc_pkg::IDX_CTL))
         rd_mux = {lap_carry_request_flag, capture_renewed_flag,
                   running, 1'b0};
      // R27 capture digits read-only
      if (hit(paddr, swc_pkg::IDX_CAP_THO))
         rd_mux = holding ? thousandths_digit : cnt_tho;
      if (hit(paddr, swc_pkg::IDX_CAP_HUN))
         rd_mux = hundredths_digit;
      if (hit(paddr, swc_pkg::IDX_CAP_TEN))
         rd_mux = tenths_digit;
      if (hit(paddr, swc_pkg::IDX_INT_EN))
         rd_mux = int_enable;
      if (hit(paddr, swc_pkg::IDX_INT_FLG))
         rd_mux = int_flag;
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {28'h0, rd_mux};
      end
   end
endmodule : swc_stopwatch

// file: swc_stopwatch_asserts.sv
// Checker of APB answers and interrupt lines.
// Bound to swc_stopwatch; sees only its ports.
`timescale 1ns/100ps
module swc_stopwatch_asserts (
   input wire logic        pclk,           // Clock
   input wire logic        presetn,        // Async reset
   input wire logic        psel,           // Select
   input wire logic        penable,        // Access phase
   input wire logic        pwrite,         // Write
   input wire logic [17:0] paddr,          // Byte address
   input wire logic [31:0] pwdata,         // Write data
   input wire logic [31:0] prdata,         // Read data
   input wire logic        pslverr,        // Error
   input wire logic        irq_key_run,    // Run irq
   input wire logic        irq_key_lap,    // Lap irq
   input wire logic        irq_unit_rate,  // 1 Hz irq
   input wire logic        irq_tenths_rate // 10 Hz irq
);
   logic [15:0] idx;
   logic        acc, mapped, int_wr, cap_rd;
   assign idx = paddr[17:2];
   assign acc = psel && penable && paddr[1:0] == 2'b00;
   assign mapped = idx inside {swc_pkg::IDX_CLK_EN, swc_pkg::IDX_DIR_CFG,
      swc_pkg::IDX_KEY_MSK, swc_pkg::IDX_CTL, swc_pkg::IDX_CAP_THO,
      swc_pkg::IDX_CAP_HUN, swc_pkg::IDX_CAP_TEN, swc_pkg::IDX_INT_EN,
      swc_pkg::IDX_INT_FLG};
   assign int_wr = acc && pwrite &&
      (idx == swc_pkg::IDX_INT_EN || idx == swc_pkg::IDX_INT_FLG);
   assign cap_rd = acc && !pwrite && idx inside {swc_pkg::IDX_CAP_THO,
      swc_pkg::IDX_CAP_HUN, swc_pkg::IDX_CAP_TEN};
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   AST_ERR_UNMAPPED: assert property (acc && !mapped |->
      pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access");
   AST_NO_ERR_MAPPED: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped register");
   AST_UPPER_ZERO: assert property (acc && !pwrite |-> prdata[31:4] == 28'h0)
      else $error("upper read bits set");
   AST_CLEAR_READS_ZERO: assert property (
      acc && !pwrite && idx == swc_pkg::IDX_CTL |-> !prdata[0])
      else $error("clear bit read as one");
   AST_CAPTURE_BCD: assert property (cap_rd |-> prdata[3:0] <= 4'h9)
      else $error("capture digit not decimal");
   AST_UNIT_STICKY: assert property ($fell(irq_unit_rate) |-> $past(int_wr))
      else $error("unit irq dropped");
   AST_TENTHS_STICKY: assert property (
      $fell(irq_tenths_rate) |-> $past(int_wr)) else $error("tenths dropped");
   AST_KEY_STICKY: assert property (
      $fell(irq_key_run) || $fell(irq_key_lap) |-> $past(int_wr))
      else $error("key irq dropped");
   AST_MASK_ALL: assert property (
      acc && pwrite && idx == swc_pkg::IDX_INT_EN && pwdata[3:0] == 4'h0
      |=> !(irq_key_run || irq_key_lap || irq_unit_rate || irq_tenths_rate))
      else $error("irq while all masked");
   COV_UNIT: cover property (irq_unit_rate);
   COV_KEY: cover property (irq_key_lap);
   COV_UNMAPPED: cover property (acc && !mapped);
endmodule : swc_stopwatch_asserts
bind swc_stopwatch swc_stopwatch_asserts u_asserts (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .irq_key_run(irq_key_run), .irq_key_lap(irq_key_lap),
   .irq_unit_rate(irq_unit_rate), .irq_tenths_rate(irq_tenths_rate));

// file: test_stopwatch_control_interrupts.sv
// Bench for the stopwatch control: registers, rates, capture, keys.
// Assumes a strobe every 8 clocks and swc_key_model on the keys.
`timescale 1ns/100ps
module test_stopwatch_control_interrupts;
   localparam logic [15:0] CKE = swc_pkg::IDX_CLK_EN,
      DIR = swc_pkg::IDX_DIR_CFG, MSK = swc_pkg::IDX_KEY_MSK,
      CTL = swc_pkg::IDX_CTL, THO = swc_pkg::IDX_CAP_THO,
      HUN = swc_pkg::IDX_CAP_HUN, TEN = swc_pkg::IDX_CAP_TEN,
      IEN = swc_pkg::IDX_INT_EN, FLG = swc_pkg::IDX_INT_FLG;
   localparam logic [15:0] REGS [9] = '{CKE, DIR, MSK, CTL, THO, HUN, TEN,
      IEN, FLG};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, slv, key_a, key_b;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdata;
   logic        irq_run, irq_lap, irq_unit, irq_ten;
   logic [5:0]  mask_keys;
   logic [3:0]  r4, h0, e0;
   int          err_count = 0, num_checks = 0, cyc = 0;
   swc_stopwatch #(.TICK_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .direct_key_pin_a(key_a), .direct_key_pin_b(key_b),
      .mask_key_in(mask_keys), .irq_key_run(irq_run), .irq_key_lap(irq_lap),
      .irq_unit_rate(irq_unit), .irq_tenths_rate(irq_ten));
   swc_key_model u_keys (.pclk(pclk), .key_a(key_a), .key_b(key_b),
      .mask_keys(mask_keys));
   task automatic chk(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic [15:0] idx, input logic wr = 1'b0,
                      input logic [3:0] wd = 4'h0);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {28'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rchk(input string what, input logic [15:0] idx,
                       input logic [3:0] exp, m = 4'hf);
      apb(idx);
      chk(what, rdata & {28'h0, m}, {28'h0, exp});
   endtask : rchk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   initial begin
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'h5a8b));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (REGS[i]) rchk("reset", REGS[i], 4'h0);
      apb(16'h0100);
      chk("unmapped error", 32'(slv), 1);
      r4 = 4'($urandom());
      apb(IEN, 1'b1, r4);
      rchk("enables", IEN, r4);
      apb(MSK, 1'b1, r4);
      rchk("key mask", MSK, r4 & 4'h7);
      apb(TEN, 1'b1, 4'hf);
      rchk("capture write", TEN, 4'h0);
      apb(CKE, 1'b1, 4'h2);
      rchk("clock enable", CKE, 4'h2, 4'h2);
      apb(IEN, 1'b1, 4'h1);
      apb(CTL, 1'b1, 4'h2);
      repeat (24) @(posedge pclk);
      rchk("running", CTL, 4'h2);
      for (int i = 0; i < 1000 && irq_ten !== 1'b1; i++) @(posedge pclk);
      chk("tenths irq", 32'(irq_ten), 1);
      repeat (8000) @(posedge pclk);
      rchk("rate flags", FLG, 4'h3, 4'h3);
      chk("unit masked", 32'(irq_unit), 0);
      apb(IEN, 1'b1, 4'h3);
      chk("unit irq", 32'(irq_unit), 1);
      apb(THO);
      apb(HUN);
      apb(TEN);
      rchk("carry request", CTL, 4'h8, 4'h8);
      apb(FLG, 1'b1, 4'h0);
      rchk("zero write", FLG, 4'h2, 4'h2);
      apb(FLG, 1'b1, 4'h2);
      rchk("flag cleared", FLG, 4'h0, 4'h2);
      apb(CTL, 1'b1, 4'h0);
      repeat (24) @(posedge pclk);
      rchk("stopped", CTL, 4'h0, 4'h2);
      apb(THO);
      apb(HUN);
      h0 = rdata[3:0];
      apb(TEN);
      e0 = rdata[3:0];
      apb(THO);
      apb(CTL, 1'b1, 4'h1);
      rchk("held hundredths", HUN, h0);
      rchk("held tenths", TEN, e0);
      apb(THO);
      rchk("cleared hundredths", HUN, 4'h0);
      rchk("cleared tenths", TEN, 4'h0);
      apb(IEN, 1'b1, 4'h0);
      apb(FLG, 1'b1, 4'hf);
      apb(DIR, 1'b1, 4'h1);
      repeat (16) @(posedge pclk);
      u_keys.press(1'b0);
      rchk("run key flag", FLG, 4'h8, 4'hc);
      chk("run irq masked", 32'(irq_run), 0);
      rchk("key started", CTL, 4'h2, 4'h2);
      apb(CTL, 1'b1, 4'h0);
      repeat (24) @(posedge pclk);
      rchk("software run", CTL, 4'h2, 4'h2);
      apb(THO);
      u_keys.press(1'b1);
      rchk("lap key flag", FLG, 4'h4, 4'h4);
      apb(HUN);
      apb(TEN);
      rchk("renewed", CTL, 4'h4, 4'h4);
      apb(TEN);
      rchk("released", CTL, 4'h0, 4'h4);
      apb(FLG, 1'b1, 4'hf);
      apb(DIR, 1'b1, 4'h3);
      rchk("direct config", DIR, 4'h3, 4'h3);
      apb(IEN, 1'b1, 4'h4);
      repeat (16) @(posedge pclk);
      u_keys.press(1'b0);
      rchk("swapped roles", FLG, 4'h4, 4'hc);
      chk("lap irq", 32'(irq_lap), 1);
      apb(FLG, 1'b1, 4'hf);
      apb(MSK, 1'b1, 4'h1);
      u_keys.hold_mask({5'($urandom()), 1'b1});
      u_keys.press(1'b1);
      rchk("masked key", FLG, 4'h0, 4'hc);
      give_verdict();
   end
endmodule : test_stopwatch_control_interrupts
